/* File: src/sync_serial_pkg.sv */
// shared constants of the synchronous serial port
package sync_serial_pkg;
    // register byte offsets on the avalon slave
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;
    localparam logic [3:0] BUF_OFS = 4'h8;
    localparam logic [3:0] ADDR_OFS = 4'hC;
    // control register fields
    localparam int CTRL_WCOL = 7;
    localparam int CTRL_OV = 6;
    localparam int CTRL_EN = 5;
    localparam int CTRL_CKP = 4;
    localparam int CTRL_MODE_HI = 3;
    // status register fields
    localparam int STAT_SMP = 7;
    localparam int STAT_CKE = 6;
    localparam int STAT_DA = 5;
    localparam int STAT_STOP = 4;
    localparam int STAT_START = 3;
    localparam int STAT_RW = 2;
    localparam int STAT_UA = 1;
    localparam int STAT_BF = 0;
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] STAT_RST = 8'h00;
    localparam logic [7:0] ADDR_RST = 8'h00;
    // mode codes held in the low control nibble
    localparam logic [3:0] MODE_M_DIV4 = 4'h0;
    localparam logic [3:0] MODE_M_DIV16 = 4'h1;
    localparam logic [3:0] MODE_M_DIV64 = 4'h2;
    localparam logic [3:0] MODE_M_SLOW = 4'h3;
    localparam logic [3:0] MODE_S_SEL = 4'h4;
    localparam logic [3:0] MODE_S_NOSEL = 4'h5;
    // serial clock half periods in system clock cycles
    localparam logic [5:0] HALF_DIV4 = 6'h02;
    localparam logic [5:0] HALF_DIV16 = 6'h08;
    localparam logic [5:0] HALF_DIV64 = 6'h20;
    localparam logic [5:0] HALF_SLOW = 6'h3F;
    // word geometry
    localparam int WORD_BITS = 8;
    localparam logic [4:0] LAST_EDGE = 5'h0F;
    localparam logic [4:0] END_TICK = 5'h10;
    localparam int FIFO_DEPTH = 4;
    // transfer sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } xfer_state_t;
endpackage

/* File: src/byte_stream_if.sv */
// valid/ready byte stream between the port and its receive fifo
`timescale 1ns/10ps
interface byte_stream_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface // byte_stream_if

/* File: src/stream_fifo.sv */
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/10ps
module stream_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    byte_stream_if.sink fill,
    byte_stream_if.source drain
);
    localparam int PW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [PW:0] cnt_q;
    logic push;
    logic pop;

    // honest full and empty straight from the fill count; the count is one bit
    // wider than the pointers, so a full count of D entries never wraps to 0
    assign fill.ready = (cnt_q != (PW + 1)'(D)) ? 1'b1 : 1'b0;
    assign drain.valid = (cnt_q != '0);
    assign drain.data = mem_q[rd_q];
    assign push = fill.valid & fill.ready;
    assign pop = drain.valid & drain.ready;

    // storage, one entry per generate step
    for (genvar i = 0; i < D; i++) begin : g_ent
        always_ff @(posedge clk_in or negedge nrst_in) begin
            if (!nrst_in) begin
                mem_q[i] <= '0;
            end else if (ce_in && push && wr_q == PW'(i)) begin
                mem_q[i] <= fill.data;
            end
        end
    end

    // pointers and count
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else if (ce_in) begin
            if (push) begin
                wr_q <= (wr_q == PW'(D - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == PW'(D - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (PW + 1)'(push) - (PW + 1)'(pop);
        end
    end
endmodule // stream_fifo

/* File: src/sync_serial_port_spi.sv */
// synchronous serial port, spi role, with avalon-mm register access
`timescale 1ns/10ps
module sync_serial_port_spi
    import sync_serial_pkg::*;
(
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe_n_out,
    input wire logic serial_in_pin_in,
    output logic serial_out_pin_out,
    output logic serial_out_oe_n_out,
    input wire logic slave_select_n_in,
    input wire logic i2c_start_seen_in,
    input wire logic i2c_stop_seen_in,
    input wire logic i2c_ack_seen_in,
    input wire logic i2c_addr_match_in,
    input wire logic i2c_rw_bit_in,
    input wire logic i2c_data_byte_in,
    input wire logic i2c_addr_update_in
);
    logic ack_q;
    logic [31:0] rdata_q;
    logic [7:0] ctrl_q;
    logic smp_q;
    logic cke_q;
    logic [7:0] own_addr_q;
    logic da_q;
    logic stop_q;
    logic start_q;
    logic rw_q;
    logic ua_q;
    logic sck_s1_q;
    logic sck_s2_q;
    logic sck_prev_q;
    logic sdi_s1_q;
    logic sdi_s2_q;
    logic ss_s1_q;
    logic ss_s2_q;
    xfer_state_t state_q;
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    logic [7:0] rx_nx;
    logic [4:0] ecnt_q;
    logic [5:0] div_q;
    logic [5:0] half;
    logic msck_q;
    logic pend_q;
    logic acc_rd;
    logic acc_wr;
    logic [3:0] mode;
    logic en;
    logic idle_clock_polarity;
    logic is_master;
    logic is_slave;
    logic is_i2c;
    logic ss_active;
    logic slave_edge;
    logic mtick;
    logic end_tick;
    logic edge_ev;
    logic [3:0] k;
    logic shift_now;
    logic samp_now;
    logic late;
    logic done_ev;
    logic busy;
    logic wr_buf;
    logic [7:0] status;

    byte_stream_if #(.W(WORD_BITS)) rx_fill ();
    byte_stream_if #(.W(WORD_BITS)) rx_drain ();

    stream_fifo #(.W(WORD_BITS), .D(FIFO_DEPTH)) u_rx_fifo (
        .clk_in(mclk_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .fill(rx_fill.sink),
        .drain(rx_drain.source)
    );

    // decoded configuration
    assign mode = ctrl_q[CTRL_MODE_HI:0];
    assign en = ctrl_q[CTRL_EN];
    assign idle_clock_polarity = ctrl_q[CTRL_CKP];
    assign is_master = en & (mode <= MODE_M_SLOW);
    assign is_slave = en & ((mode == MODE_S_SEL) | (mode == MODE_S_NOSEL));
    assign is_i2c = en & ~is_master & ~is_slave;
    assign ss_active = (mode != MODE_S_SEL) | ~ss_s2_q;
    assign busy = (state_q == ST_RUN) | pend_q | (is_slave & (ecnt_q != '0));

    // avalon: every access waits exactly one cycle, then completes
    assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;
    assign acc_rd = avs_read_in & ack_q;
    assign acc_wr = avs_write_in & ack_q & avs_byteenable_in[0];
    assign wr_buf = acc_wr & (avs_address_in == BUF_OFS);
    assign avs_readdata_out = rdata_q;

    assign status = {smp_q, cke_q, da_q, stop_q, start_q, rw_q, ua_q, rx_drain.valid};

    // bus acknowledge and registered read data
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ack_q <= 1'b0;
            rdata_q <= '0;
        end else if (ce_in) begin
            ack_q <= (avs_read_in | avs_write_in) & ~ack_q;
            if (avs_read_in && !ack_q) begin
                case (avs_address_in)
                    CTRL_OFS: rdata_q <= {24'h000000, ctrl_q};
                    STAT_OFS: rdata_q <= {24'h000000, status};
                    BUF_OFS: rdata_q <= {24'h000000, rx_drain.data};
                    ADDR_OFS: rdata_q <= {24'h000000, own_addr_q};
                    default: rdata_q <= '0; // unmapped reads zero
                endcase
            end
        end
    end

    // reading the buffer frees its fifo slot
    assign rx_drain.ready = acc_rd & (avs_address_in == BUF_OFS);

    // control register; hardware sets of the sticky errors win over a clear
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctrl_q <= CTRL_RST;
        end else if (ce_in) begin
            if (acc_wr && avs_address_in == CTRL_OFS) begin
                ctrl_q <= avs_writedata_in[7:0];
            end
            if (wr_buf && busy) begin
                ctrl_q[CTRL_WCOL] <= 1'b1;
            end
            if (done_ev && !rx_fill.ready) begin
                ctrl_q[CTRL_OV] <= 1'b1; // word lost, fifo was full
            end
        end
    end

    // writable status bits and own address
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            smp_q <= STAT_RST[STAT_SMP];
            cke_q <= STAT_RST[STAT_CKE];
            own_addr_q <= ADDR_RST;
        end else if (ce_in) begin
            if (acc_wr && avs_address_in == STAT_OFS) begin
                smp_q <= avs_writedata_in[STAT_SMP];
                cke_q <= avs_writedata_in[STAT_CKE];
            end
            if (acc_wr && avs_address_in == ADDR_OFS) begin
                own_addr_q <= avs_writedata_in[7:0];
            end
        end
    end

    // bus condition flags reported by the i2c engine
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            start_q <= STAT_RST[STAT_START];
            stop_q <= STAT_RST[STAT_STOP];
            rw_q <= STAT_RST[STAT_RW];
            da_q <= STAT_RST[STAT_DA];
            ua_q <= STAT_RST[STAT_UA];
        end else if (ce_in) begin
            if (!is_i2c) begin
                start_q <= 1'b0;
                stop_q <= 1'b0;
                rw_q <= 1'b0;
            end else begin
                if (i2c_start_seen_in) begin
                    start_q <= 1'b1;
                    stop_q <= 1'b0;
                end else if (i2c_stop_seen_in) begin
                    stop_q <= 1'b1;
                    start_q <= 1'b0;
                end
                // capture wins over the clearing conditions
                if (i2c_addr_match_in) begin
                    rw_q <= i2c_rw_bit_in;
                end else if (i2c_start_seen_in || i2c_stop_seen_in || i2c_ack_seen_in) begin
                    rw_q <= 1'b0;
                end
                da_q <= i2c_data_byte_in;
                ua_q <= i2c_addr_update_in;
            end
        end
    end

    // pin synchronisers, two stages before any use
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sck_s1_q <= 1'b0;
            sck_s2_q <= 1'b0;
            sdi_s1_q <= 1'b0;
            sdi_s2_q <= 1'b0;
            ss_s1_q <= 1'b1;
            ss_s2_q <= 1'b1;
        end else if (ce_in) begin
            sck_s1_q <= sck_in;
            sck_s2_q <= sck_s1_q;
            sdi_s1_q <= serial_in_pin_in;
            sdi_s2_q <= sdi_s1_q;
            ss_s1_q <= slave_select_n_in;
            ss_s2_q <= ss_s1_q;
        end
    end

    // slave edge finder; outside slave mode the reference sits at idle,
    // so a line not at idle on enable would fake an edge
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sck_prev_q <= 1'b0;
        end else if (ce_in) begin
            sck_prev_q <= is_slave ? sck_s2_q : idle_clock_polarity;
        end
    end
    assign slave_edge = is_slave & ss_active & (sck_s2_q != sck_prev_q);

    // master clock rate from the mode, ignored in slave operation
    always_comb begin
        case (mode)
            MODE_M_DIV4: half = HALF_DIV4;
            MODE_M_DIV16: half = HALF_DIV16;
            MODE_M_DIV64: half = HALF_DIV64;
            default: half = HALF_SLOW;
        endcase
    end

    // master sequencer: 16 clock toggles then one idle half period
    assign mtick = (state_q == ST_RUN) & (div_q == '0);
    assign end_tick = mtick & (ecnt_q == END_TICK);
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q <= ST_IDLE;
            div_q <= '0;
            msck_q <= 1'b0;
            pend_q <= 1'b0;
        end else if (ce_in) begin
            case (state_q)
                ST_IDLE: begin
                    msck_q <= idle_clock_polarity;
                    if (wr_buf && !busy) begin
                        pend_q <= is_master;
                    end else if (pend_q && is_master && rx_fill.ready) begin
                        pend_q <= 1'b0; // start only with room for the reply
                        div_q <= half - 1'b1;
                        state_q <= ST_RUN;
                    end else if (!is_master) begin
                        pend_q <= 1'b0;
                    end
                end
                ST_RUN: begin
                    if (!is_master) begin
                        state_q <= ST_IDLE;
                    end else if (mtick) begin
                        div_q <= half - 1'b1;
                        if (end_tick) begin
                            state_q <= ST_IDLE;
                        end else begin
                            msck_q <= ~msck_q;
                        end
                    end else begin
                        div_q <= div_q - 1'b1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // edge bookkeeping: even edges leave idle, odd edges return to it
    assign edge_ev = (mtick & ~end_tick) | slave_edge;
    assign k = ecnt_q[3:0];
    assign late = smp_q & is_master;
    assign shift_now = edge_ev & (cke_q ? (k[0] & (k != 4'hF)) : (~k[0] & (k != 4'h0)));
    always_comb begin
        samp_now = 1'b0;
        if (edge_ev) begin
            if (late) begin
                samp_now = cke_q ? k[0] : (~k[0] & (k != 4'h0));
            end else begin
                samp_now = cke_q ? ~k[0] : k[0];
            end
        end
        if (end_tick && late && !cke_q) begin
            samp_now = 1'b1; // last late sample after the final edge
        end
    end
    assign done_ev = is_master ? end_tick : (slave_edge & (ecnt_q == LAST_EDGE));
    assign rx_nx = samp_now ? {rx_q[6:0], sdi_s2_q} : rx_q;

    // edge counter, cleared per word and when the select goes away
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ecnt_q <= '0;
        end else if (ce_in) begin
            if (!en || (is_slave && !ss_active) || done_ev || (state_q == ST_IDLE && is_master)) begin
                ecnt_q <= '0;
            end else if (edge_ev || end_tick) begin
                ecnt_q <= ecnt_q + 1'b1;
            end
        end
    end

    // shift registers: msb out first, in from the data input
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tx_q <= '0;
            rx_q <= '0;
        end else if (ce_in) begin
            rx_q <= rx_nx;
            if (wr_buf && !busy) begin
                tx_q <= avs_writedata_in[7:0];
            end else if (shift_now) begin
                tx_q <= {tx_q[6:0], 1'b0};
            end
        end
    end

    // completed word enters the receive fifo unless it is full, and raises buffer full
    assign rx_fill.valid = done_ev;
    assign rx_fill.data = rx_nx;

    // pins: enables are active low while driving
    assign sck_out = msck_q;
    assign sck_oe_n_out = ~is_master;
    assign serial_out_pin_out = tx_q[7];
    assign serial_out_oe_n_out = ~(is_master | (is_slave & ss_active));
endmodule // sync_serial_port_spi

/* File: testbench/spi_port_monitor.sv */
// pin-level checks of the spi serial port
`timescale 1ns/10ps
module spi_port_monitor
    import sync_serial_pkg::*;
(
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic sck_out,
    input wire logic sck_oe_n_out,
    input wire logic serial_out_oe_n_out,
    input wire logic slave_select_n_in
);
    logic [5:0] ctrl_q;
    logic [1:0] opt_q;
    logic last_q;
    logic [5:0] gap_q;
    logic done_w;
    logic master_w;
    logic rd_done_w;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);
    // completed writes and reads as the bus sees them
    assign done_w = !avs_waitrequest_out && avs_write_in && avs_byteenable_in[0];
    assign rd_done_w = !avs_waitrequest_out && avs_read_in;
    assign master_w = ctrl_q[5] && (ctrl_q[3:0] < MODE_S_SEL);
    // shadow of software-owned option bits; hardware flags stay unknown here
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctrl_q <= 6'h00;
            opt_q <= 2'h0;
        end else if (done_w && avs_address_in == CTRL_OFS) begin
            ctrl_q <= avs_writedata_in[5:0];
        end else if (done_w && avs_address_in == STAT_OFS) begin
            opt_q <= avs_writedata_in[7:6];
        end
    end
    // cycles since the serial clock last moved, saturating
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            last_q <= 1'b0;
            gap_q <= 6'h3F;
        end else begin
            last_q <= sck_out;
            gap_q <= (sck_out != last_q) ? 6'h00 : ((gap_q == 6'h3F) ? gap_q : gap_q + 6'h01);
        end
    end
    wait_first_a: assert property ($rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out)
        else $error("no wait state on new access");
    wait_once_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out) else $error("access not answered after one wait");
    clk_dir_a: assert property ($stable(ctrl_q) |-> sck_oe_n_out == !master_w)
        else $error("serial clock direction wrong");
    idle_lvl_a: assert property (!ctrl_q[5] && $stable(ctrl_q) |-> sck_out == ctrl_q[4])
        else $error("serial clock idle level wrong");
    half_per_a: assert property (sck_out != last_q && master_w && ctrl_q[3:0] == MODE_M_DIV16
        && $stable(ctrl_q) |-> gap_q >= (HALF_DIV16 - 6'h01)) else $error("clock half period short");
    out_drv_a: assert property (master_w && $stable(ctrl_q) |-> !serial_out_oe_n_out)
        else $error("master not driving data out");
    sel_off_a: assert property (ctrl_q[5] && ctrl_q[3:0] == MODE_S_SEL && ctrl_q == $past(ctrl_q, 3)
        && $past(slave_select_n_in, 2) && $past(slave_select_n_in, 3) && $past(slave_select_n_in, 4)
        |-> serial_out_oe_n_out) else $error("data out driven while deselected");
    unmapped_a: assert property (rd_done_w && avs_address_in[1:0] != 2'h0
        |-> avs_readdata_out == 32'h0) else $error("unmapped read not zero");
    stat_opt_a: assert property (rd_done_w && avs_address_in == STAT_OFS
        |-> avs_readdata_out[7:6] == opt_q && avs_readdata_out[31:8] == 24'h0)
        else $error("status option bits wrong");
    cover property (master_w && sck_out != last_q);
    cover property (rd_done_w && avs_address_in == BUF_OFS);
    cover property (ctrl_q[5] && ctrl_q[3:0] == MODE_S_SEL && !serial_out_oe_n_out);
endmodule // spi_port_monitor

bind sync_serial_port_spi spi_port_monitor mon (.mclk_in(mclk_in), .nrst_in(nrst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .sck_out(sck_out), .sck_oe_n_out(sck_oe_n_out), .serial_out_oe_n_out(serial_out_oe_n_out),
    .slave_select_n_in(slave_select_n_in));

/* File: testbench/spi_peer_model.sv */
// behavioural far-side spi device, slave to the port or master of it
`timescale 1ns/10ps
module spi_peer_model (
    input wire logic cpol_in,
    input wire logic sck_line_in,
    input wire logic sdo_line_in,
    output logic sdi_out,
    output logic sck_drv_out
);
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    // msb leads on the wire
    assign sdi_out = tx_q[7];
    initial begin
        tx_q = 8'h00;
        rx_q = 8'h00;
        sck_drv_out = 1'b0;
    end
    // sample leaving idle, shift returning to idle
    always @(sck_line_in) begin
        if (sck_line_in !== cpol_in) begin
            rx_q <= {rx_q[6:0], sdo_line_in};
        end else begin
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end
    // config changes wiggle the line, so loading also clears what was caught
    task automatic load(input logic [7:0] word);
        tx_q = word;
        rx_q = 8'h00;
    endtask
    // clock parked at idle before the port is made slave
    task automatic park(input logic level);
        sck_drv_out = level;
    endtask
    // one word of sixteen edges at 48 ns period, clock still afterwards
    task automatic run_master();
        repeat (16) begin
            #24;
            sck_drv_out = !sck_drv_out;
        end
    endtask
endmodule // spi_peer_model

/* File: testbench/tb.sv */
// self-checking bench of the spi serial port
`timescale 1ns/10ps
module tb;
    import sync_serial_pkg::*;
    logic mclk_in, nrst_in, rd, wr, sck_o, sck_oe_n, serial_out_pin, sdo_oe_n, ss_n, cpol;
    logic sdo_last = 1'b0;
    logic sck_drv, serial_in_pin, rwb, wait_w;
    logic [3:0] addr, be, ev;
    logic [1:0] lvl;
    logic [31:0] wdata, rdata;
    logic [7:0] v;
    wire sck_line;
    wire sdo_line;
    int n_errors;
    int num_checks;
    sync_serial_port_spi dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .ce_in(1'b1),
        .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_w),
        .sck_in(sck_line), .sck_out(sck_o), .sck_oe_n_out(sck_oe_n), .serial_in_pin_in(serial_in_pin),
        .serial_out_pin_out(serial_out_pin), .serial_out_oe_n_out(sdo_oe_n), .slave_select_n_in(ss_n),
        .i2c_start_seen_in(ev[0]), .i2c_stop_seen_in(ev[1]), .i2c_ack_seen_in(ev[2]),
        .i2c_addr_match_in(ev[3]), .i2c_rw_bit_in(rwb), .i2c_data_byte_in(lvl[1]),
        .i2c_addr_update_in(lvl[0]));
    spi_peer_model peer (.cpol_in(cpol), .sck_line_in(sck_line), .sdo_line_in(sdo_line),
        .sdi_out(serial_in_pin), .sck_drv_out(sck_drv));
    // wire levels; a released data line shows the opposite of its last value
    assign sck_line = sck_oe_n ? sck_drv : sck_o;
    assign sdo_line = sdo_oe_n ? !sdo_last : serial_out_pin;
    always @(posedge mclk_in) if (!sdo_oe_n) sdo_last <= serial_out_pin;
    initial begin
        mclk_in = 1'b0;
        forever #2.5 mclk_in = !mclk_in;
    end
    task automatic results();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one avalon access, held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                       input logic [3:0] b);
        int n;
        @(posedge mclk_in);
        addr <= a;
        rd <= !w;
        wr <= w;
        wdata <= {24'h0, d};
        be <= b;
        n = 0;
        // the rising edge that sees waitrequest low completes the access
        do begin
            @(posedge mclk_in);
            n++;
        end while (wait_w !== 1'b0 && n < 20);
        v = rdata[7:0];
        if (wait_w !== 1'b0) chk("waitrequest", 8'h00, 8'h01);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wr8(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask
    task automatic rd_chk(input string name, input logic [3:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00, 4'hF);
        chk(name, exp, v);
    endtask
    task automatic pulse(input logic [3:0] e);
        @(posedge mclk_in);
        ev <= e;
        @(posedge mclk_in);
        ev <= 4'h0;
    endtask
    task automatic t_reset();
        rd_chk("ctrl_rst", CTRL_OFS, CTRL_RST);
        rd_chk("stat_rst", STAT_OFS, STAT_RST);
        rd_chk("addr_rst", ADDR_OFS, ADDR_RST);
        chk("sck_oe_rst", 8'h01, {7'h0, sck_oe_n});
    endtask
    // writable masks, lane enable, unmapped place
    task automatic t_regs();
        wr8(STAT_OFS, 8'hFF);
        rd_chk("stat_mask", STAT_OFS, 8'hC0);
        wr8(ADDR_OFS, 8'h5A);
        bus(1'b1, ADDR_OFS, 8'hA5, 4'h0);
        rd_chk("own_addr", ADDR_OFS, 8'h5A);
        rd_chk("unmapped", 4'h2, 8'h00);
        wr8(CTRL_OFS, 8'h0F);
        rd_chk("ctrl_rw", CTRL_OFS, 8'h0F);
    endtask
    task automatic t_master(input logic p, input logic [7:0] tx, input logic [7:0] px);
        int n;
        cpol = p;
        wr8(STAT_OFS, 8'h40);
        wr8(CTRL_OFS, {3'b001, p, MODE_M_DIV16}); // select input stays high
        repeat (20) @(posedge mclk_in);
        chk("sck_idle", {7'h0, p}, {7'h0, sck_o});
        chk("sck_drive", 8'h00, {7'h0, sck_oe_n});
        peer.load(px);
        wr8(BUF_OFS, tx);
        v = 8'h00;
        for (n = 0; n < 60 && v[0] !== 1'b1; n++) bus(1'b0, STAT_OFS, 8'h00, 4'hF);
        chk("bf_set", 8'h41, v);
        rd_chk("m_rx", BUF_OFS, px);
        chk("peer_rx", tx, peer.rx_q);
        rd_chk("bf_clr", STAT_OFS, 8'h40);
    endtask
    // five words into a four-word buffer, the bus not reading meanwhile
    task automatic t_slave();
        int i;
        cpol = 1'b0;
        wr8(CTRL_OFS, 8'h00);
        peer.park(1'b0);
        wr8(STAT_OFS, 8'h40); // sample phase left clear
        wr8(CTRL_OFS, {4'h2, MODE_S_SEL});
        wr8(BUF_OFS, 8'hC3);
        repeat (5) @(posedge mclk_in);
        chk("sck_input", 8'h01, {7'h0, sck_oe_n});
        chk("sel_off", 8'h01, {7'h0, sdo_oe_n});
        ss_n <= 1'b0;
        repeat (5) @(posedge mclk_in);
        chk("sel_on", 8'h00, {7'h0, sdo_oe_n});
        for (i = 0; i < 5; i++) begin
            peer.load(8'hA0 + 8'(i));
            peer.run_master();
            repeat (10) @(posedge mclk_in);
            if (i == 0) chk("s_peer_rx", 8'hC3, peer.rx_q);
        end
        rd_chk("overflow", CTRL_OFS, 8'h64);
        for (i = 0; i < 4; i++) rd_chk("s_rx", BUF_OFS, 8'hA0 + 8'(i));
        rd_chk("s_empty", STAT_OFS, 8'h40);
        ss_n <= 1'b1;
    endtask
    task automatic t_i2c();
        lvl <= 2'b11;
        wr8(CTRL_OFS, 8'h26);
        pulse(4'h1);
        rd_chk("start", STAT_OFS, 8'h6A);
        rwb <= 1'b1;
        pulse(4'h8);
        rd_chk("dir_read", STAT_OFS, 8'h6E);
        pulse(4'h4);
        rd_chk("dir_ack", STAT_OFS, 8'h6A);
        pulse(4'h2);
        rd_chk("stop", STAT_OFS, 8'h72);
    endtask
    initial begin
        n_errors = 0;
        num_checks = 0;
        {nrst_in, rd, wr, cpol, rwb} = 5'h00;
        {addr, be, ev, lvl, wdata} = '0;
        ss_n = 1'b1;
        repeat (5) @(posedge mclk_in);
        nrst_in <= 1'b1;
        t_reset();
        t_regs();
        t_master(1'b0, 8'h96, 8'h3C);
        t_master(1'b1, 8'h5B, 8'hE1);
        t_slave();
        t_i2c();
        results();
    end
    // watchdog well past the thousand or so cycles the tests need
    initial begin
        #50000;
        chk("watchdog", 8'h00, 8'h01);
        results();
    end
endmodule // tb
